// >>> rtl/pabo_port_ab_override.sv
// Alternate-function override logic for the first and second general I/O ports
// How it works
// - First-port pull-up, direction and value overrides stay off at zero.
// - First-port input-enable override is mask AND group enable, OR converter disable.
// - First-port pin n feeds converter channel n and pin-change source n.
// - Serial clock pin forced input as slave; follows direction bit as master.
// - Master-in pin forced input as master; follows direction bit as slave.
// - Master-out pin forced input as slave; follows direction bit as master.
// - Slave-select pin forced input as slave; follows direction bit as master.
// - A forced-input SPI pin keeps its pull-up under the port output bit.
// - Compare-B output drives bit 4 only when its direction bit is one.
// - Compare-A output drives bit 3 only when its direction bit is one.
// - Bits 3 and 2 go straight to comparator negative and positive inputs.
// - Bit 2 also serves as external interrupt source two.
// - Second-port bits 7..0 feed pin-change sources 15..8.
// - Bit 1 is timer one count input and clock out; bit 0 timer zero and USART clock.
// - Without override, pull-up on only for direction/port/disable equal 0,1,0.
// - Driver enable follows override value when enabled, else the direction bit.
// - Input enable follows override value when enabled, else the normal/sleep state.
module pabo_port_ab_override (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Pin pads, first port
    input wire logic [7:0] pa_pad_in,
    output logic [7:0] pa_pad_out,
    output logic [7:0] pa_pad_oe,
    output logic [7:0] pa_pullup_en,
    output logic [7:0] pa_input_en,
    // Pin pads, second port
    input wire logic [7:0] pb_pad_in,
    output logic [7:0] pb_pad_out,
    output logic [7:0] pb_pad_oe,
    output logic [7:0] pb_pullup_en,
    output logic [7:0] pb_input_en,
    // Port registers
    input wire logic [7:0] port1_direction_bits,
    input wire logic [7:0] port1_output_bits,
    input wire logic [7:0] port2_direction_bit,
    input wire logic [7:0] port2_output_bit,
    input wire logic global_pullup_disable,
    input wire logic sleep_input_disable,
    // Pin-change and converter controls
    input wire logic [7:0] pin_change_mask_port1,
    input wire logic pin_change_group0_enable,
    input wire logic [7:0] pin_change_mask_port2,
    input wire logic pin_change_group1_enable,
    input wire logic [7:0] converter_digin_disable_bit,
    input wire logic external_irq_two_enable,
    // SPI controls and data
    input wire logic spi_enable,
    input wire logic spi_master,
    input wire logic spi_clock_out,
    input wire logic spi_slave_data_out,
    input wire logic spi_master_data_out,
    // Timer and clock-out controls
    input wire logic timer_zero_compare_a_en,
    input wire logic timer_zero_compare_a_out,
    input wire logic timer_zero_compare_b_en,
    input wire logic timer_zero_compare_b_out,
    input wire logic clock_out_enable,
    input wire logic clock_out_src,
    input wire logic usart_zero_clock_drive,
    input wire logic usart_zero_clock_out,
    // Peripheral-side digital inputs
    output logic [15:0] pin_change_sources,
    output logic [7:0] converter_input_channels,
    output logic comparator_positive_in,
    output logic comparator_negative_in,
    output logic external_irq_two,
    output logic spi_clock_in,
    output logic spi_master_data_in,
    output logic spi_slave_data_in,
    output logic spi_slave_select_n,
    output logic timer_zero_count_in,
    output logic timer_one_count_in,
    output logic usart_zero_ext_clock,
    // Status
    output logic spi_pins_forced
);

    // Registered state: reset synchroniser and a pin-forced status flag
    typedef struct packed {
        logic [1:0] rst_sync;
        logic forced;
    } pabo_state_t;

    pabo_state_t state_ff;
    pabo_state_t nxt_state;
    logic rst_sync_n;

    // Override vectors, first port
    logic [7:0] pa_pullup_override_enable;
    logic [7:0] pa_pullup_override_value;
    logic [7:0] pa_direction_override_enable;
    logic [7:0] pa_direction_override_value;
    logic [7:0] pa_portval_override_enable;
    logic [7:0] pa_portval_override_value;
    logic [7:0] pa_input_en_override_enable;
    logic [7:0] pa_input_en_override_value;
    // Override vectors, second port
    logic [7:0] pb_pullup_override_enable;
    logic [7:0] pb_pullup_override_value;
    logic [7:0] pb_direction_override_enable;
    logic [7:0] pb_direction_override_value;
    logic [7:0] pb_portval_override_enable;
    logic [7:0] pb_portval_override_value;
    logic [7:0] pb_input_en_override_enable;
    logic [7:0] pb_input_en_override_value;
    // Forced-pin pull-up level and armed pin-change inputs, second port
    logic [7:0] pb_keep_pullup;
    logic [7:0] pb_pc_armed;
    logic spi_slave_mode;
    logic spi_master_mode;

    assign rst_sync_n = state_ff.rst_sync[1];
    assign spi_master_mode = spi_enable & spi_master;
    assign spi_slave_mode = spi_enable & ~spi_master;
    assign pb_keep_pullup = port2_output_bit & {8{~global_pullup_disable}};
    assign pb_pc_armed = pin_change_mask_port2 & {8{pin_change_group1_enable}};

    // First-port override signals
    always_comb begin
        pa_pullup_override_enable = pabo_pkg::OVR_OFF;
        pa_pullup_override_value = pabo_pkg::OVR_OFF;
        pa_direction_override_enable = pabo_pkg::OVR_OFF;
        pa_direction_override_value = pabo_pkg::OVR_OFF;
        pa_portval_override_enable = pabo_pkg::OVR_OFF;
        pa_portval_override_value = pabo_pkg::OVR_OFF;
    end

    // First-port input enable: an armed pin change or a converter disable takes over
    always_comb begin
        pa_input_en_override_value = pin_change_mask_port1 & {8{pin_change_group0_enable}};
        pa_input_en_override_enable = pa_input_en_override_value | converter_digin_disable_bit;
    end

    // Second-port override signals, one group per pin; forced SPI inputs keep the pull-up
    always_comb begin
        // Serial clock: input as slave, SPI clock output as master
        pb_pullup_override_enable[pabo_pkg::PB_SCK] = spi_slave_mode;
        pb_pullup_override_value[pabo_pkg::PB_SCK] = pb_keep_pullup[pabo_pkg::PB_SCK];
        pb_direction_override_enable[pabo_pkg::PB_SCK] = spi_slave_mode;
        pb_direction_override_value[pabo_pkg::PB_SCK] = 1'h0;
        pb_portval_override_enable[pabo_pkg::PB_SCK] = spi_master_mode;
        pb_portval_override_value[pabo_pkg::PB_SCK] = spi_clock_out;
        pb_input_en_override_enable[pabo_pkg::PB_SCK] = pb_pc_armed[pabo_pkg::PB_SCK];
        pb_input_en_override_value[pabo_pkg::PB_SCK] = 1'h1;

        // Master-in data: input as master, slave data output as slave
        pb_pullup_override_enable[pabo_pkg::PB_MISO] = spi_master_mode;
        pb_pullup_override_value[pabo_pkg::PB_MISO] = pb_keep_pullup[pabo_pkg::PB_MISO];
        pb_direction_override_enable[pabo_pkg::PB_MISO] = spi_master_mode;
        pb_direction_override_value[pabo_pkg::PB_MISO] = 1'h0;
        pb_portval_override_enable[pabo_pkg::PB_MISO] = spi_slave_mode;
        pb_portval_override_value[pabo_pkg::PB_MISO] = spi_slave_data_out;
        pb_input_en_override_enable[pabo_pkg::PB_MISO] = pb_pc_armed[pabo_pkg::PB_MISO];
        pb_input_en_override_value[pabo_pkg::PB_MISO] = 1'h1;

        // Master-out data: input as slave, master data output as master
        pb_pullup_override_enable[pabo_pkg::PB_MOSI] = spi_slave_mode;
        pb_pullup_override_value[pabo_pkg::PB_MOSI] = pb_keep_pullup[pabo_pkg::PB_MOSI];
        pb_direction_override_enable[pabo_pkg::PB_MOSI] = spi_slave_mode;
        pb_direction_override_value[pabo_pkg::PB_MOSI] = 1'h0;
        pb_portval_override_enable[pabo_pkg::PB_MOSI] = spi_master_mode;
        pb_portval_override_value[pabo_pkg::PB_MOSI] = spi_master_data_out;
        pb_input_en_override_enable[pabo_pkg::PB_MOSI] = pb_pc_armed[pabo_pkg::PB_MOSI];
        pb_input_en_override_value[pabo_pkg::PB_MOSI] = 1'h1;

        // Slave select: input as slave; compare-B reaches it only via the direction bit
        pb_pullup_override_enable[pabo_pkg::PB_SSEL] = spi_slave_mode;
        pb_pullup_override_value[pabo_pkg::PB_SSEL] = pb_keep_pullup[pabo_pkg::PB_SSEL];
        pb_direction_override_enable[pabo_pkg::PB_SSEL] = spi_slave_mode;
        pb_direction_override_value[pabo_pkg::PB_SSEL] = 1'h0;
        pb_portval_override_enable[pabo_pkg::PB_SSEL] = timer_zero_compare_b_en;
        pb_portval_override_value[pabo_pkg::PB_SSEL] = timer_zero_compare_b_out;
        pb_input_en_override_enable[pabo_pkg::PB_SSEL] = pb_pc_armed[pabo_pkg::PB_SSEL];
        pb_input_en_override_value[pabo_pkg::PB_SSEL] = 1'h1;

        // Comparator negative pin; compare-A reaches it only via the direction bit
        pb_pullup_override_enable[pabo_pkg::PB_CMPN] = 1'h0;
        pb_pullup_override_value[pabo_pkg::PB_CMPN] = 1'h0;
        pb_direction_override_enable[pabo_pkg::PB_CMPN] = 1'h0;
        pb_direction_override_value[pabo_pkg::PB_CMPN] = 1'h0;
        pb_portval_override_enable[pabo_pkg::PB_CMPN] = timer_zero_compare_a_en;
        pb_portval_override_value[pabo_pkg::PB_CMPN] = timer_zero_compare_a_out;
        pb_input_en_override_enable[pabo_pkg::PB_CMPN] = pb_pc_armed[pabo_pkg::PB_CMPN];
        pb_input_en_override_value[pabo_pkg::PB_CMPN] = 1'h1;

        // Comparator positive pin; interrupt two keeps its digital input alive
        pb_pullup_override_enable[pabo_pkg::PB_CMPP] = 1'h0;
        pb_pullup_override_value[pabo_pkg::PB_CMPP] = 1'h0;
        pb_direction_override_enable[pabo_pkg::PB_CMPP] = 1'h0;
        pb_direction_override_value[pabo_pkg::PB_CMPP] = 1'h0;
        pb_portval_override_enable[pabo_pkg::PB_CMPP] = 1'h0;
        pb_portval_override_value[pabo_pkg::PB_CMPP] = 1'h0;
        pb_input_en_override_enable[pabo_pkg::PB_CMPP] = pb_pc_armed[pabo_pkg::PB_CMPP]
            | external_irq_two_enable;
        pb_input_en_override_value[pabo_pkg::PB_CMPP] = 1'h1;

        // Divided clock output takes the pin regardless of port settings
        pb_pullup_override_enable[pabo_pkg::PB_T1] = 1'h0;
        pb_pullup_override_value[pabo_pkg::PB_T1] = 1'h0;
        pb_direction_override_enable[pabo_pkg::PB_T1] = clock_out_enable;
        pb_direction_override_value[pabo_pkg::PB_T1] = clock_out_enable;
        pb_portval_override_enable[pabo_pkg::PB_T1] = clock_out_enable;
        pb_portval_override_value[pabo_pkg::PB_T1] = clock_out_src;
        pb_input_en_override_enable[pabo_pkg::PB_T1] = pb_pc_armed[pabo_pkg::PB_T1];
        pb_input_en_override_value[pabo_pkg::PB_T1] = 1'h1;

        // USART clock driven when the direction bit makes it an output
        pb_pullup_override_enable[pabo_pkg::PB_T0] = 1'h0;
        pb_pullup_override_value[pabo_pkg::PB_T0] = 1'h0;
        pb_direction_override_enable[pabo_pkg::PB_T0] = 1'h0;
        pb_direction_override_value[pabo_pkg::PB_T0] = 1'h0;
        pb_portval_override_enable[pabo_pkg::PB_T0] = usart_zero_clock_drive;
        pb_portval_override_value[pabo_pkg::PB_T0] = usart_zero_clock_out;
        pb_input_en_override_enable[pabo_pkg::PB_T0] = pb_pc_armed[pabo_pkg::PB_T0];
        pb_input_en_override_value[pabo_pkg::PB_T0] = 1'h1;
    end

    // Generic port logic applying the overrides to each pin
    always_comb begin
        for (int i = 0; i < pabo_pkg::PORT_W; i++) begin
            pa_pullup_en[i] = pa_pullup_override_enable[i] ? pa_pullup_override_value[i] :
                ({port1_direction_bits[i], port1_output_bits[i], global_pullup_disable}
                 == pabo_pkg::PULLUP_PATTERN);
            pb_pullup_en[i] = pb_pullup_override_enable[i] ? pb_pullup_override_value[i] :
                ({port2_direction_bit[i], port2_output_bit[i], global_pullup_disable}
                 == pabo_pkg::PULLUP_PATTERN);
        end
    end

    // Output driver enable per pin
    always_comb begin
        for (int i = 0; i < pabo_pkg::PORT_W; i++) begin
            pa_pad_oe[i] = pa_direction_override_enable[i] ? pa_direction_override_value[i] : port1_direction_bits[i];
            pb_pad_oe[i] = pb_direction_override_enable[i] ? pb_direction_override_value[i] : port2_direction_bit[i];
        end
    end

    // Port value per pin
    always_comb begin
        for (int i = 0; i < pabo_pkg::PORT_W; i++) begin
            pa_pad_out[i] = pa_portval_override_enable[i] ? pa_portval_override_value[i] : port1_output_bits[i];
            pb_pad_out[i] = pb_portval_override_enable[i] ? pb_portval_override_value[i] : port2_output_bit[i];
        end
    end

    // Digital input enable per pin; sleep may switch unclaimed inputs off
    always_comb begin
        for (int i = 0; i < pabo_pkg::PORT_W; i++) begin
            pa_input_en[i] = pa_input_en_override_enable[i] ? pa_input_en_override_value[i] : ~sleep_input_disable;
            pb_input_en[i] = pb_input_en_override_enable[i] ? pb_input_en_override_value[i] : ~sleep_input_disable;
        end
    end

    // Digital and analog routes to the peripherals, without added delay
    always_comb begin
        converter_input_channels = pa_pad_in;
        pin_change_sources = {pb_pad_in & pb_input_en, pa_pad_in & pa_input_en};
    end

    // Comparator taps straight from the pads; external interrupt two gated by its input enable
    always_comb begin
        comparator_negative_in = pb_pad_in[pabo_pkg::PB_CMPN];
        comparator_positive_in = pb_pad_in[pabo_pkg::PB_CMPP];
        external_irq_two = pb_pad_in[pabo_pkg::PB_CMPP] & pb_input_en[pabo_pkg::PB_CMPP];
    end

    // SPI inputs; the peripheral synchronises them itself
    always_comb begin
        spi_clock_in = pb_pad_in[pabo_pkg::PB_SCK];
        spi_master_data_in = pb_pad_in[pabo_pkg::PB_MISO];
        spi_slave_data_in = pb_pad_in[pabo_pkg::PB_MOSI];
        // Active-low select; held inactive unless slave mode
        spi_slave_select_n = spi_slave_mode ? pb_pad_in[pabo_pkg::PB_SSEL] : 1'b1;
    end

    // Timer count inputs and the USART external clock
    always_comb begin
        timer_one_count_in = pb_pad_in[pabo_pkg::PB_T1];
        timer_zero_count_in = pb_pad_in[pabo_pkg::PB_T0];
        usart_zero_ext_clock = pb_pad_in[pabo_pkg::PB_T0];
    end

    // Next state: shift reset synchroniser, record whether any SPI pin is forced
    always_comb begin
        nxt_state = state_ff;
        nxt_state.rst_sync = {state_ff.rst_sync[0], 1'b1};
        nxt_state.forced = rst_sync_n & (|pb_direction_override_enable[7:4]);
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= '{rst_sync: pabo_pkg::STATE_RST, forced: 1'b0};
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign spi_pins_forced = state_ff.forced;

endmodule

// >>> rtl/pabo_pkg.sv
// Package with pin positions and encodings for the port A/B alternate-function override block
package pabo_pkg;
    // Port widths
    localparam int PORT_W = 8;
    // Second-port pin positions
    localparam int PB_SCK = 7;
    localparam int PB_MISO = 6;
    localparam int PB_MOSI = 5;
    localparam int PB_SSEL = 4;
    localparam int PB_CMPN = 3;
    localparam int PB_CMPP = 2;
    localparam int PB_T1 = 1;
    localparam int PB_T0 = 0;
    // Pull-up enable pattern for {direction, port bit, global disable}
    localparam logic [2:0] PULLUP_PATTERN = 3'h2;
    // Inactive override level
    localparam logic [7:0] OVR_OFF = 8'h00;
    // All-ones byte for constant override values
    localparam logic [7:0] OVR_ON = 8'hff;
    // Reset value of the reset synchroniser bits in the registered state
    localparam logic [1:0] STATE_RST = 2'h0;
endpackage

// >>> verification/pabo_override_asserts.sv
// Concurrent checks on the port A/B override block, bound to its top module
module pabo_override_asserts (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Pads and port registers
    input wire logic [7:0] pa_pad_in, pa_pad_oe, pa_pad_out, pa_pullup_en, pa_input_en,
    input wire logic [7:0] pb_pad_in, pb_pad_oe, pb_pullup_en, pb_input_en,
    input wire logic [7:0] port1_direction_bits, port1_output_bits,
    input wire logic [7:0] port2_direction_bit, port2_output_bit,
    input wire logic global_pullup_disable, sleep_input_disable, spi_enable, spi_master,
    // Converter, pin-change and peripheral inputs
    input wire logic [7:0] pin_change_mask_port1, converter_digin_disable_bit,
    input wire logic pin_change_group0_enable,
    input wire logic [7:0] converter_input_channels,
    input wire logic [15:0] pin_change_sources,
    input wire logic comparator_positive_in, comparator_negative_in, external_irq_two,
    input wire logic spi_slave_select_n, spi_pins_forced
);
    logic [7:0] pa_pc;
    logic slv;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Group-gated mask and slave-mode helper terms
    assign pa_pc = pin_change_mask_port1 & {8{pin_change_group0_enable}};
    assign slv = spi_enable & !spi_master;
    // Pin relations checked at every rising clock edge while rst_n is high
    AST_PA_FIXED: assert property (pa_pad_oe == port1_direction_bits && pa_pad_out == port1_output_bits) else $error("port A override active");
    AST_PA_PULLUP: assert property (pa_pullup_en == (~port1_direction_bits & port1_output_bits & {8{!global_pullup_disable}})) else $error("port A pull-up wrong");
    AST_PA_INEN: assert property (pa_input_en == (pa_pc | (~(pa_pc | converter_digin_disable_bit) & {8{!sleep_input_disable}}))) else $error("port A input enable wrong");
    AST_PA_ROUTE: assert property (converter_input_channels == pa_pad_in && pin_change_sources[7:0] == (pa_pad_in & pa_input_en)) else $error("port A routing wrong");
    AST_SLAVE_DIR: assert property (slv |-> (pb_pad_oe[7:4] & 4'hb) == 4'h0 && pb_pad_oe[6] == port2_direction_bit[6]) else $error("slave pins not forced");
    AST_MASTER_DIR: assert property (spi_enable && spi_master |-> pb_pad_oe[7:4] == (port2_direction_bit[7:4] & 4'hb)) else $error("master pins wrong");
    AST_FORCED_PU: assert property (slv |-> pb_pullup_en[7] == (port2_output_bit[7] & !global_pullup_disable)) else $error("forced pull-up wrong");
    AST_SSEL: assert property (slv |-> spi_slave_select_n == pb_pad_in[4]) else $error("select not from pin");
    AST_CMP: assert property (comparator_negative_in == pb_pad_in[3] && comparator_positive_in == pb_pad_in[2]) else $error("comparator routing wrong");
    AST_IRQ2: assert property (external_irq_two == (pb_pad_in[2] & pb_input_en[2])) else $error("irq two wrong");
    AST_PB_SRC: assert property (pin_change_sources[15:8] == (pb_pad_in & pb_input_en)) else $error("port B sources wrong");
    AST_PB_PU_DEF: assert property (!spi_enable |-> pb_pullup_en == (~port2_direction_bit & port2_output_bit & {8{!global_pullup_disable}})) else $error("port B pull-up wrong");
    AST_FORCED_FLAG: assert property (spi_enable [*4] |-> spi_pins_forced) else $error("forced flag missing");
    // Main scenarios reached
    cover property (slv);
    cover property (spi_enable && spi_master);
    cover property (pin_change_group0_enable && |pin_change_mask_port1);
endmodule

bind pabo_port_ab_override pabo_override_asserts pabo_override_asserts_inst (.*);

// >>> verification/pabo_pad_model.sv
// Pad-side model: own driver, an outside agent and the pull-up on eight pins
module pabo_pad_model (
    input wire logic clk,
    input wire logic [7:0] oe, out, pull, ext_en, ext_val,
    output logic [7:0] pad
);
    logic [7:0] wobble = 8'h00;
    // Floating pins change every cycle so no stale level survives
    always @(posedge clk) wobble <= ~wobble;
    // Own driver wins, then the outside agent, then pull-up or floating level
    assign pad = (oe & out) | (~oe & ext_en & ext_val) | (~oe & ~ext_en & (pull | wobble));
endmodule

// >>> verification/test_port_a_b_alternate_pin_override.sv
// Self-checking bench for the port A/B alternate-function override block
module test_port_a_b_alternate_pin_override;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, rst_n, global_pullup_disable, sleep_input_disable, pin_change_group0_enable;
    logic pin_change_group1_enable, external_irq_two_enable, spi_enable, spi_master;
    logic spi_clock_out, spi_slave_data_out, spi_master_data_out, timer_zero_compare_a_en;
    logic timer_zero_compare_a_out, timer_zero_compare_b_en, timer_zero_compare_b_out;
    logic clock_out_enable, clock_out_src, usart_zero_clock_drive, usart_zero_clock_out;
    logic comparator_positive_in, comparator_negative_in, external_irq_two, spi_clock_in;
    logic spi_master_data_in, spi_slave_data_in, spi_slave_select_n, timer_zero_count_in;
    logic timer_one_count_in, usart_zero_ext_clock, spi_pins_forced;
    logic [7:0] pa_pad_in, pa_pad_out, pa_pad_oe, pa_pullup_en, pa_input_en, pb_pad_in;
    logic [7:0] pb_pad_out, pb_pad_oe, pb_pullup_en, pb_input_en, port1_direction_bits;
    logic [7:0] port1_output_bits, port2_direction_bit, port2_output_bit, pin_change_mask_port1;
    logic [7:0] pin_change_mask_port2, converter_digin_disable_bit, converter_input_channels;
    logic [7:0] ext_a_en, ext_a_val, ext_b_en, ext_b_val, pe;
    logic [15:0] pin_change_sources;
    int bad_count = 0;
    int num_checks = 0;
    // Block under test and the two pad sides
    pabo_port_ab_override pabo_port_ab_override_inst (.*);
    pabo_pad_model pabo_pad_model_inst (.clk, .oe(pa_pad_oe), .out(pa_pad_out),
        .pull(pa_pullup_en), .ext_en(ext_a_en), .ext_val(ext_a_val), .pad(pa_pad_in));
    pabo_pad_model pabo_pad_model_inst_b (.clk, .oe(pb_pad_oe), .out(pb_pad_out),
        .pull(pb_pullup_en), .ext_en(ext_b_en), .ext_val(ext_b_val), .pad(pb_pad_in));
    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic step();
        @(posedge clk);
        #1;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Watchdog well beyond the twenty-nine cycles the tests need
    initial begin
        #20000;
        bad_count++;
        print_verdict();
    end
    // Test sequence
    initial begin
        {global_pullup_disable, sleep_input_disable, pin_change_group0_enable, spi_enable,
            pin_change_group1_enable, external_irq_two_enable, spi_master, spi_clock_out,
            spi_slave_data_out, spi_master_data_out, timer_zero_compare_a_en, clock_out_src,
            timer_zero_compare_a_out, timer_zero_compare_b_en, timer_zero_compare_b_out,
            clock_out_enable, usart_zero_clock_drive, usart_zero_clock_out} = '0;
        {port1_direction_bits, port1_output_bits, port2_direction_bit, port2_output_bit} = '0;
        {pin_change_mask_port1, pin_change_mask_port2, converter_digin_disable_bit} = '0;
        {ext_a_en, ext_a_val, ext_b_en, ext_b_val} = '0;
        rst_n = 1'b0;
        repeat (16) @(posedge clk);
        #1 rst_n = 1'b1;
        // Port A: no direction overrides, gated input enable, routing
        port1_direction_bits = 8'h0f;
        port1_output_bits = 8'h3c;
        pin_change_mask_port1 = 8'h5a;
        converter_digin_disable_bit = 8'h83;
        ext_a_en = 8'hf0;
        ext_a_val = 8'h60;
        for (int g = 0; g < 2; g++) begin
            step();
            pin_change_group0_enable = g[0];
            #1;
            pe = g ? 8'h7e : 8'h7c;
            check(pa_input_en, pe);
            check({pa_pad_oe, pa_pad_out}, 16'h0f3c);
            check(pa_pullup_en, 8'h30);
            check(converter_input_channels, 8'h6c);
            check(pin_change_sources[7:0], 8'h6c & pe);
        end
        $display("port A test done");
        // SPI slave then master; outside master holds select low
        step();
        port2_direction_bit = 8'hff;
        port2_output_bit = 8'hd0;
        {spi_clock_out, spi_slave_data_out, spi_master_data_out} = 3'h7;
        ext_b_en = 8'h10;
        for (int m = 0; m < 2; m++) begin
            step();
            spi_enable = 1'b1;
            spi_master = m[0];
            #1;
            check(pb_pad_oe, m ? 8'hbf : 8'h4f);
            check(pb_pullup_en, m ? 8'h40 : 8'h90);
            check(spi_slave_select_n, m[0]);
            if (m)
                check(pb_pad_out[5], 1'b1);
            repeat (2) step();
            check(spi_pins_forced, 1'b1);
        end
        $display("SPI test done");
        // Timer compare outputs and clock out
        step();
        spi_enable = 1'b0;
        port2_direction_bit = 8'h18;
        port2_output_bit = 8'h10;
        {timer_zero_compare_a_en, timer_zero_compare_a_out, timer_zero_compare_b_en} = 3'h7;
        {clock_out_enable, clock_out_src} = 2'h3;
        #1;
        check(pb_pad_oe, 8'h1a);
        check({pb_pad_out[4:3], pb_pad_out[1]}, 3'h3);
        step();
        port2_direction_bit = 8'h00;
        #1;
        check(pb_pad_oe[4:3], 2'h0);
        check(pb_pullup_en, 8'h10);
        $display("timer test done");
        // Port B routing to peripherals
        step();
        clock_out_enable = 1'b0;
        {ext_b_en, ext_b_val, pin_change_mask_port2} = {8'hff, 8'h96, 8'hff};
        {pin_change_group1_enable, external_irq_two_enable, sleep_input_disable} = 3'h7;
        #1;
        check(pin_change_sources[15:8], 8'h96);
        check({comparator_negative_in, comparator_positive_in}, 2'h1);
        check(external_irq_two, 1'b1);
        check({timer_one_count_in, timer_zero_count_in, usart_zero_ext_clock}, 3'h4);
        check({spi_clock_in, spi_master_data_in, spi_slave_data_in}, 3'h4);
        step();
        pin_change_group1_enable = 1'b0;
        #1;
        check(pin_change_sources[15:8], 8'h04);
        $display("routing test done");
        print_verdict();
    end
endmodule
